// ---- inc/mtsr_pkg.sv ----
package mtsr_pkg;
    // ==========================================
    // Register numbers on the system control port
    localparam logic [4:0] REG_PAGE_TABLE_POINTER = 5'h04;
    localparam logic [4:0] REG_PAGE_SIZE_MASK = 5'h05;
    localparam logic [4:0] REG_FIXED_ENTRY_BOUNDARY = 5'h06;
    localparam logic [4:0] REG_FAULTING_VIRTUAL_ADDRESS = 5'h08;
    // ==========================================
    // Field layout
    localparam int BASE_LSB = 23;
    localparam int BASE_W = 9;
    localparam int FPN_LSB = 4;
    localparam int FPN_W = 19;
    localparam int VA_FPN_LSB = 13;
    localparam int MASK_LSB = 13;
    localparam int MASK_W = 12;
    localparam int BOUND_W = 4;
    localparam logic [3:0] BOUND_RESET = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // ==========================================
    // Coherency attribute codes
    localparam logic [2:0] CCA_WRITE_THROUGH = 3'h3;
    localparam logic [2:0] CCA_UNCACHED = 3'h2;
    localparam logic [2:0] CCA_UNUSED_UNCACHED = 3'h7;
    // ==========================================
    // Exception kinds reported by the pipeline
    typedef enum logic [2:0] {
        MTSR_EXC_NONE = 3'h0,
        MTSR_EXC_LOAD_ADDR = 3'h1,
        MTSR_EXC_STORE_ADDR = 3'h2,
        MTSR_EXC_REFILL = 3'h3,
        MTSR_EXC_INVALID = 3'h4,
        MTSR_EXC_MODIFIED = 3'h5,
        MTSR_EXC_CACHE_ERR = 3'h6,
        MTSR_EXC_BUS_ERR = 3'h7
    } mtsr_exc_t;
endpackage

// ---- inc/mtsr_rand_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Link between the register file and the replacement index generator
interface mtsr_rand_if #(parameter int IDX_W = 4);
    logic [IDX_W-1:0] bound;
    logic reload;
    logic [IDX_W-1:0] index;
    modport regs(output bound, output reload, input index);
    modport gen(input bound, input reload, output index);
endinterface
`default_nettype wire

// ---- hdl/mtsr_random_index.sv ----
`timescale 1ns/100ps
`default_nettype none
module mtsr_random_index
    import mtsr_pkg::*;
#(
    parameter int ENTRIES = 16,
    parameter int IDX_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    mtsr_rand_if.gen rif
);
    typedef struct packed {
        logic [IDX_W-1:0] index;
        logic [7:0] lfsr;
    } mtsr_rnd_state_t;

    localparam logic [IDX_W-1:0] TOP = IDX_W'(ENTRIES - 1);
    localparam logic [7:0] LFSR_SEED = 8'h01;

    mtsr_rnd_state_t state_reg;
    mtsr_rnd_state_t state_next;

    assign rif.index = state_reg.index;

    // ==========================================
    // Decrement, skipped now and then by an LFSR to break lockstep
    always_comb begin
        state_next = state_reg;
        state_next.lfsr = {state_reg.lfsr[6:0],
                           state_reg.lfsr[7] ^ state_reg.lfsr[5] ^ state_reg.lfsr[4] ^ state_reg.lfsr[3]};
        if (rif.reload) begin
            state_next.index = TOP;
        end else if (!(state_reg.lfsr[7] & state_reg.lfsr[0])) begin
            // Wrap at the boundary so entries below it are never victims
            if (state_reg.index <= rif.bound) begin
                state_next.index = TOP;
            end else begin
                state_next.index = state_reg.index - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{index: TOP, lfsr: LFSR_SEED};
        end else begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/mtsr_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Unused coherency codes 0,1,4,5,6 map to 3; code 7 maps to 2.
// - Refill, invalid, modified exceptions load VA 31:13 into pointer bits 22:4.
// - Faulting page field left unspecified after address errors; here unchanged.
// - Faulting page field is read-only to software; hardware writes it.
// - Page table base bits 31:23 are software read/write, never hardware changed.
// - Reserved bits of pointer, mask and boundary registers read zero.
// - Each set mask bit removes that VA bit from entry comparison.
// - Mask bits fill upward from bit 13, two per page size step.
// - Entries below the boundary are never random victims; indexed writes allowed.
// - Boundary register clears to zero on reset.
// - Writing the boundary reloads random index with entry count minus one.
// - Faulting address captures VA of address error and translation exceptions.
// - Faulting address unchanged on cache and bus errors.
// - Pointer forms a 16-byte entry address: base, page number, zero low bits.
// - Fixed-mapping builds treat pointer, mask and boundary as reserved.
// - Random index decrements nearly every clock, wrapping at the boundary.
module mtsr_regs
    import mtsr_pkg::*;
#(
    parameter int ENTRIES = 16,
    parameter bit FIXED_MAPPING = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [4:0] reg_num,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [2:0] exc_kind,
    input wire logic [31:0] exc_vaddr,
    input wire logic [31:0] cmp_vaddr,
    input wire logic [2:0] cca_in,
    output logic [2:0] cca_out,
    output logic [31:0] cmp_vaddr_masked,
    output logic [3:0] random_index,
    output logic [3:0] boundary_out
);
    localparam int IDX_W = 4;

    typedef struct packed {
        // Software-owned pointer base, hardware-owned page number
        logic [BASE_W-1:0] base;
        logic [FPN_W-1:0] fpn;
        // Page size and fixed entry boundary
        logic [MASK_W-1:0] mask;
        logic [BOUND_W-1:0] bound;
        // Last addressing fault
        logic [31:0] fault_va;
        // Output copies, so every port leaves a flop
        logic [31:0] rdata;
        logic [2:0] cca;
        logic [31:0] masked;
        logic [IDX_W-1:0] rnd;
        logic [BOUND_W-1:0] bound_q;
    } mtsr_state_t;

    mtsr_state_t state_reg;
    mtsr_state_t state_next;
    logic rst_n;
    logic [1:0] rst_q;

    mtsr_rand_if #(.IDX_W(IDX_W)) rif();

    // ==========================================
    // Reset release through two flops
    // No state flop may see reset leave close to a clock edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    mtsr_random_index #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_rand (
        .clk(clk),
        .rst_n(rst_n),
        .rif(rif)
    );

    // ==========================================
    // Coherency code remap; only 2 and 3 exist in this core
    function automatic logic [2:0] mtsr_remap_cca(input logic [2:0] code);
        if (code == CCA_UNCACHED || code == CCA_UNUSED_UNCACHED) begin
            mtsr_remap_cca = CCA_UNCACHED;
        end else begin
            mtsr_remap_cca = CCA_WRITE_THROUGH;
        end
    endfunction

    // Register view by number; reserved bits stay zero
    function automatic logic [31:0] mtsr_view(input logic [4:0] num, input mtsr_state_t s);
        mtsr_view = WORD_ZERO;
        case (num)
            REG_PAGE_TABLE_POINTER: begin
                if (!FIXED_MAPPING) begin
                    mtsr_view[BASE_LSB +: BASE_W] = s.base;
                    mtsr_view[FPN_LSB +: FPN_W] = s.fpn;
                end
            end
            REG_PAGE_SIZE_MASK: begin
                if (!FIXED_MAPPING) begin
                    mtsr_view[MASK_LSB +: MASK_W] = s.mask;
                end
            end
            REG_FIXED_ENTRY_BOUNDARY: begin
                if (!FIXED_MAPPING) begin
                    mtsr_view[BOUND_W-1:0] = s.bound;
                end
            end
            REG_FAULTING_VIRTUAL_ADDRESS: mtsr_view = s.fault_va;
            default: mtsr_view = WORD_ZERO;
        endcase
    endfunction

    // ==========================================
    // Write decode
    // Mapped registers vanish in fixed-mapping builds
    function automatic logic mtsr_mapped_hit(input logic [4:0] num, input logic [4:0] target);
        mtsr_mapped_hit = (num == target) && !FIXED_MAPPING;
    endfunction

    logic ptr_wr;
    logic mask_wr;
    logic bound_wr;
    assign ptr_wr = reg_write && mtsr_mapped_hit(reg_num, REG_PAGE_TABLE_POINTER);
    assign mask_wr = reg_write && mtsr_mapped_hit(reg_num, REG_PAGE_SIZE_MASK);
    assign bound_wr = reg_write && mtsr_mapped_hit(reg_num, REG_FIXED_ENTRY_BOUNDARY);

    // Boundary feeds the generator; any boundary write restarts it at the top
    assign rif.bound = state_reg.bound;
    assign rif.reload = bound_wr;

    // ==========================================
    // Exception classes
    // Translation faults carry a page number for the refill handler
    function automatic logic mtsr_is_xlat_exc(input logic [2:0] kind);
        case (kind)
            MTSR_EXC_REFILL, MTSR_EXC_INVALID, MTSR_EXC_MODIFIED: begin
                mtsr_is_xlat_exc = 1'b1;
            end
            default: begin
                mtsr_is_xlat_exc = 1'b0;
            end
        endcase
    endfunction

    // Address errors only touch the fault address
    function automatic logic mtsr_is_addr_exc(input logic [2:0] kind);
        case (kind)
            MTSR_EXC_LOAD_ADDR, MTSR_EXC_STORE_ADDR: begin
                mtsr_is_addr_exc = 1'b1;
            end
            default: begin
                mtsr_is_addr_exc = 1'b0;
            end
        endcase
    endfunction

    logic xlat_exc;
    logic addr_exc;
    logic fault_capture;
    assign xlat_exc = mtsr_is_xlat_exc(exc_kind);
    assign addr_exc = mtsr_is_addr_exc(exc_kind);
    // Cache and bus errors are not addressing faults, so they capture nothing
    assign fault_capture = xlat_exc || addr_exc;

    // ==========================================
    // Compare address masking, one gate per mask bit
    logic [MASK_W-1:0] mask_keep;
    genvar gi;
    generate
        for (gi = 0; gi < MASK_W; gi = gi + 1) begin : g_mask
            // A set mask bit takes the address bit out of the match
            assign mask_keep[gi] = cmp_vaddr[MASK_LSB + gi] & ~state_reg.mask[gi];
        end
    endgenerate

    // ==========================================
    // Next state
    always_comb begin
        state_next = state_reg;
        // Software writes; the page number field has no write path
        if (ptr_wr) begin
            state_next.base = reg_wdata[BASE_LSB +: BASE_W];
        end
        if (mask_wr) begin
            state_next.mask = reg_wdata[MASK_LSB +: MASK_W];
        end
        if (bound_wr) begin
            state_next.bound = reg_wdata[BOUND_W-1:0];
        end
        // Hardware capture; fault fields and software fields never overlap
        if (xlat_exc && !FIXED_MAPPING) begin
            state_next.fpn = exc_vaddr[VA_FPN_LSB +: FPN_W];
        end
        if (fault_capture) begin
            state_next.fault_va = exc_vaddr;
        end
        if (reg_read) begin
            state_next.rdata = mtsr_view(reg_num, state_reg);
        end
        state_next.cca = mtsr_remap_cca(cca_in);
        // Bits outside the mask field pass straight through
        state_next.masked = cmp_vaddr;
        state_next.masked[MASK_LSB +: MASK_W] = mask_keep;
        state_next.rnd = rif.index;
        state_next.bound_q = state_reg.bound;
    end

    // Undefined-at-reset fields still get zero for clean simulation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign cca_out = state_reg.cca;
    assign cmp_vaddr_masked = state_reg.masked;
    assign random_index = state_reg.rnd;
    assign boundary_out = state_reg.bound_q;
endmodule
`default_nettype wire

// ---- test/mtsr_pipe_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// Pipeline side: one exception report per call
module mtsr_pipe_model import mtsr_pkg::*; (
    input wire logic clk,
    output logic [2:0] exc_kind,
    output logic [31:0] exc_vaddr
);
    initial begin
        exc_kind = MTSR_EXC_NONE;
        exc_vaddr = 32'h0000_0000;
    end
    // Address turns to its inverse after the pulse, so a stale value never matches
    task automatic raise(input logic [2:0] kind, input logic [31:0] va);
        @(negedge clk);
        exc_kind = kind;
        exc_vaddr = va;
        @(negedge clk);
        exc_kind = MTSR_EXC_NONE;
        exc_vaddr = ~va;
    endtask
endmodule
`default_nettype wire

// ---- test/mtsr_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// Checks on the register block ports
module mtsr_chk #(parameter int ENTRIES = 16, parameter bit FIXED_MAPPING = 1'b0) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [4:0] reg_num,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] cmp_vaddr,
    input wire logic [31:0] cmp_vaddr_masked,
    input wire logic [2:0] cca_in,
    input wire logic [2:0] cca_out,
    input wire logic [3:0] random_index,
    input wire logic [3:0] boundary_out
);
    localparam logic [3:0] TOP = 4'(ENTRIES - 1);
    logic [2:0] up_reg;
    logic ok;
    // Settle count: the block frees its own reset two edges late
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) up_reg <= 3'h0;
        else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
    end
    assign ok = up_reg == 3'h4;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_bound_wr;
        ok && reg_write && reg_num == 5'h06 && !FIXED_MAPPING;
    endsequence
    // Boundary copy and index copy both reach the ports one edge after the write edge
    sequence s_reload;
        ##1 boundary_out == $past(reg_wdata[3:0], 2) && random_index == TOP;
    endsequence
    a_cca_remap: assert property (ok |=> cca_out == (($past(cca_in) == 3'h2 || $past(cca_in) == 3'h7) ? 3'h2 : 3'h3))
        else $error("coherency remap wrong");
    a_mask_outside: assert property (ok |=> cmp_vaddr_masked[31:25] == $past(cmp_vaddr[31:25])
        && cmp_vaddr_masked[12:0] == $past(cmp_vaddr[12:0])) else $error("masked address outside mask");
    a_bound_reload: assert property (s_bound_wr |=> s_reload) else $error("index not reloaded");
    a_victim_range: assert property (ok && $stable(boundary_out) |-> random_index >= boundary_out)
        else $error("index below boundary");
    a_index_step: assert property (ok && $past(ok) && random_index != $past(random_index)
        |-> random_index == $past(random_index) - 4'h1 || random_index == TOP) else $error("index step");
    a_ptr_low: assert property (reg_read && reg_num == 5'h04 |=> reg_rdata[3:0] == 4'h0)
        else $error("pointer low bits");
    a_mask_rsvd: assert property (reg_read && reg_num == 5'h05 |=> reg_rdata[31:25] == 7'h00
        && reg_rdata[12:0] == 13'h0000) else $error("mask reserved bits");
    a_bound_read: assert property (ok && reg_read && !reg_write && reg_num == 5'h06
        |=> reg_rdata == {28'h000_0000, boundary_out}) else $error("boundary readback");
endmodule
bind mtsr_regs mtsr_chk #(.ENTRIES(ENTRIES), .FIXED_MAPPING(FIXED_MAPPING)) u_chk (.clk(clk), .reset_n(reset_n),
    .reg_write(reg_write),
    .reg_read(reg_read), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cmp_vaddr(cmp_vaddr), .cmp_vaddr_masked(cmp_vaddr_masked), .cca_in(cca_in), .cca_out(cca_out),
    .random_index(random_index), .boundary_out(boundary_out));
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import mtsr_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [4:0] reg_num = 5'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, cmp_vaddr = 32'h0000_0000;
    logic [2:0] cca_in = 3'h0;
    logic [31:0] reg_rdata, cmp_vaddr_masked, exc_vaddr, fx_rdata;
    logic [2:0] exc_kind, cca_out;
    logic [3:0] random_index, boundary_out;
    int mismatches = 0, n_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    mtsr_regs DUT (.clk(clk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
        .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .exc_kind(exc_kind),
        .exc_vaddr(exc_vaddr), .cmp_vaddr(cmp_vaddr), .cca_in(cca_in), .cca_out(cca_out),
        .cmp_vaddr_masked(cmp_vaddr_masked), .random_index(random_index), .boundary_out(boundary_out));
    // Fixed-mapping build on the same inputs; only its read data goes to chk, the bound checker judges its other ports
    mtsr_regs #(.FIXED_MAPPING(1'b1)) dut_fixed (.clk(clk), .reset_n(reset_n), .reg_write(reg_write),
        .reg_read(reg_read), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(fx_rdata),
        .exc_kind(exc_kind), .exc_vaddr(exc_vaddr), .cmp_vaddr(cmp_vaddr), .cca_in(cca_in), .cca_out(),
        .cmp_vaddr_masked(), .random_index(), .boundary_out());
    mtsr_pipe_model pm (.clk(clk), .exc_kind(exc_kind), .exc_vaddr(exc_vaddr));
    // ====
    // Shared compare and register access
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] num, input logic [31:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_num = num;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
    endtask
    // Read data is registered on the taking edge, so look at the next falling edge
    task automatic rc(input logic [4:0] num, input logic [31:0] exp, input string what);
        @(negedge clk);
        reg_read = 1'b1;
        reg_num = num;
        @(negedge clk);
        reg_read = 1'b0;
        chk(what, exp, reg_rdata);
    endtask
    // Boundary clear after reset, base writable, page field not
    task automatic t_ptr();
        rc(REG_FIXED_ENTRY_BOUNDARY, 32'h0000_0000, "boundary");
        rc(5'h1F, 32'h0000_0000, "unmapped");
        wr(REG_PAGE_TABLE_POINTER, 32'hFFFF_FFFF);
        rc(REG_PAGE_TABLE_POINTER, 32'hFF80_0000, "pointer");
        chk("fixed pointer", 32'h0000_0000, fx_rdata);
    endtask
    // Each exception kind; writes to the fault address must be dropped
    task automatic t_exc();
        logic [31:0] fva, ptr, va;
        fva = 32'h0000_0000;
        ptr = 32'hFF80_0000;
        for (int k = 1; k < 8; k++) begin
            va = 32'h2468_ACE1 ^ {k[3:0], 28'h000_0000};
            pm.raise(k[2:0], va);
            if (k <= 5) fva = va;
            if (k >= 3 && k <= 5) ptr = {ptr[31:23], va[31:13], 4'h0};
            wr(REG_FAULTING_VIRTUAL_ADDRESS, 32'h0000_0000);
            rc(REG_FAULTING_VIRTUAL_ADDRESS, fva, "fault address");
            chk("fixed fault address", fva, fx_rdata);
            rc(REG_PAGE_TABLE_POINTER, ptr, "pointer page");
        end
    endtask
    // All page sizes, readback and effect on the compare address
    task automatic t_mask();
        logic [11:0] m;
        cmp_vaddr = 32'hFFFF_FFFF;
        for (int s = 0; s < 7; s++) begin
            m = 12'((1 << (2 * s)) - 1);
            wr(REG_PAGE_SIZE_MASK, {7'h00, m, 13'h0000});
            rc(REG_PAGE_SIZE_MASK, {7'h00, m, 13'h0000}, "page mask");
            chk("masked address", ~{7'h00, m, 13'h0000}, cmp_vaddr_masked);
        end
    endtask
    task automatic t_cca();
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            cca_in = c[2:0];
            @(negedge clk);
            chk("coherency", (c == 2 || c == 7) ? 32'h2 : 32'h3, {29'h0, cca_out});
        end
    endtask
    // Boundary write reloads the index, which then stays at or above it and wraps
    task automatic t_wired();
        logic lo, wrap;
        lo = 1'b0;
        wrap = 1'b0;
        wr(REG_FIXED_ENTRY_BOUNDARY, 32'h0000_0005);
        // Reloaded index shows on the port one edge after the write edge
        @(negedge clk);
        chk("reload", 32'h0000_000F, {28'h0, random_index});
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if (random_index < 4'h5) chk("victim", 32'h5, {28'h0, random_index});
            if (random_index == 4'h5) lo = 1'b1;
            if (lo && random_index == 4'hF) wrap = 1'b1;
        end
        chk("wrap seen", 32'h1, {31'h0, wrap});
        chk("boundary out", 32'h0000_0005, {28'h0, boundary_out});
        rc(REG_FIXED_ENTRY_BOUNDARY, 32'h0000_0005, "boundary");
        chk("fixed boundary", 32'h0000_0000, fx_rdata);
    endtask
    // Reset in mid-run clears the boundary and puts the index back at the top
    task automatic t_reset();
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("index after reset", 32'h0000_000F, {28'h0, random_index});
        rc(REG_FIXED_ENTRY_BOUNDARY, 32'h0000_0000, "boundary after reset");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        t_ptr();
        t_exc();
        t_mask();
        t_cca();
        t_wired();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
